// *** hw/readout_pkg.sv ***
/*
  Constants, encodings and state types for the calibration pattern readout block.
  Assumes the command pins are already decoded to active-low levels on the device clock.
*/
package readout_pkg;

  // Calibration-mode register layout: bits 16:14 come from the bank lines, 13:0 from address.
  localparam int          MODE_W         = 17;
  localparam logic [16:0] MODE_RESET     = 17'h00000;
  localparam int          BIT_ENABLE     = 2;
  localparam int          BIT_FSEL_LO    = 0;
  localparam int          BIT_FSEL_HI    = 1;
  localparam logic [16:0] MODE_RSVD_MASK = 17'h13FF0;
  localparam logic [1:0]  FSEL_PATTERN   = 2'h0;

  // Bank code that selects the calibration-mode register on a mode-register load.
  localparam logic [2:0]  BANK_MODE3     = 3'h3;

  // Command codes as {cs_n, ras_n, cas_n, we_n}.
  localparam logic [3:0]  CMD_LOAD       = 4'h0;
  localparam logic [3:0]  CMD_READ       = 4'h5;

  // Address positions used by a pattern read.
  localparam int          ADDR_NIBBLE    = 2;
  localparam int          ADDR_CHOP      = 12;

  // Burst selection from the base mode register.
  localparam logic [1:0]  BURST_FIXED8   = 2'h0;
  localparam logic [1:0]  BURST_OTF      = 2'h1;
  localparam logic [1:0]  BURST_FIXED4   = 2'h2;

  // Pattern, burst lengths and latency pipe depth.
  localparam logic [7:0]  CAL_PATTERN    = 8'hAA;
  localparam logic [2:0]  LAST_FULL      = 3'h7;
  localparam logic [2:0]  LAST_CHOP      = 3'h3;
  localparam logic [2:0]  START_UPPER    = 3'h4;
  localparam logic [2:0]  START_LOWER    = 3'h0;
  localparam int          LAT_DEPTH      = 32;
  localparam int          SYNC_STAGES    = 2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SEND = 2'h1
  } burst_state_e;

endpackage : readout_pkg

// *** hw/level_sync.sv ***
/*
  Two-stage synchroniser for slow levels and toggles.
  Assumes each input bit changes at most once per several destination clocks.
*/
`timescale 1ns/1ns
module level_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock.
  input  wire logic             clk,
  // Source levels and their synchronised copies.
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] d_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] hold_q;

  // Left without reset on purpose: one bit carries the reset itself, and both settle in two edges.
  always_ff @(posedge clk)
  begin
    meta_q <= d_in;
    hold_q <= meta_q;
  end

  assign d_out = hold_q;

endmodule : level_sync

// *** hw/calibration_readout.sv ***
/*
  Calibration-mode register and pattern readout logic of the DRAM, command side on the link clock.
  Assumes command, address, latency settings and DLL lock are synchronous to ck; srst lives on clk.
*/
// How it works
// - The calibration-mode register keeps its value until reloaded or reset.
// - Loading the register never touches array contents.
// - Function-select bits are ignored while readout is disabled.
// - Bit 2 low gives array reads; high gives pattern data on reads.
// - Select 00 is the calibration pattern; other codes are reserved and unused.
// - While enabled, every read or auto-precharge read goes to the pattern register.
// - Reset still works while readout is enabled.
// - Narrow parts put the bit on line 0 and drive other lines low.
// - Wide parts put the bit on lines 0 and 8, others low.
// - Pattern reads support full and chopped bursts with normal latency when DLL locked.
// - With on-the-fly selection, address 12 picks chop-four or full eight.
// - Full bursts use address 2 zero and deliver beats 0 to 7.
// - Chopped bursts use beats 0-3 with address 2 low, 4-7 high.
// - First beat maps to pattern bit 0, last beat to bit 7.
// - Address bits 9-3, 10, 11, 13 and bank bits are ignored on pattern reads.
// - Pattern is alternating 0,1 over eight beats or four beats.
// - A load with bank code 011 targets the calibration-mode register.
// - Pattern appears additive plus CAS latency cycles after the read.
`timescale 1ns/1ns
module calibration_readout (
  // Core clock and reset.
  input  wire logic        clk,
  input  wire logic        srst,
  // Link clock and command pins.
  input  wire logic        ck,
  input  wire logic        cs_n,
  input  wire logic        ras_n,
  input  wire logic        cas_n,
  input  wire logic        we_n,
  input  wire logic [2:0]  ba,
  input  wire logic [13:0] addr,
  // Settings owned by the base mode register and the DLL.
  input  wire logic [1:0]  burst_select,
  input  wire logic [4:0]  additive_latency,
  input  wire logic [4:0]  cas_read_latency,
  input  wire logic        dll_locked,
  // Width strap, captured while reset is held.
  input  wire logic        dev_x16,
  // Data lines, read direction only.
  output logic [15:0]      dq_o,
  output logic             dq_oe,
  // Core-side status.
  output logic             readout_on,
  output logic             array_read_pulse
);

  logic [1:0]                  link_in_sync;
  logic                        link_rst;
  logic                        x16_sync;
  logic [3:0]                  cmd;
  logic                        mode_load;
  logic                        any_read;
  logic                        pat_read;
  logic                        norm_read;
  logic                        push;
  logic                        req_chop;
  logic [readout_pkg::MODE_W-1:0] mode_q;
  logic [readout_pkg::MODE_W-1:0] mode_d;
  logic                        wide_q;
  logic                        wide_d;
  logic                        rd_tog_q;
  logic                        rd_tog_d;
  logic [readout_pkg::LAT_DEPTH-1:0] lat_v_q;
  logic [readout_pkg::LAT_DEPTH-1:0] lat_v_d;
  logic [readout_pkg::LAT_DEPTH-1:0] lat_c_q;
  logic [readout_pkg::LAT_DEPTH-1:0] lat_c_d;
  logic [readout_pkg::LAT_DEPTH-1:0] lat_n_q;
  logic [readout_pkg::LAT_DEPTH-1:0] lat_n_d;
  logic [5:0]                  rl_sum;
  logic [4:0]                  tap;
  logic                        launch;
  logic                        launch_chop;
  logic                        launch_nib;
  logic                        reload;
  readout_pkg::burst_state_e   state_q;
  readout_pkg::burst_state_e   state_d;
  logic [2:0]                  beat_q;
  logic [2:0]                  beat_d;
  logic [2:0]                  last_q;
  logic [2:0]                  last_d;
  logic [15:0]                 dq_q;
  logic [15:0]                 dq_d;
  logic                        oe_q;
  logic                        oe_d;
  logic [1:0]                  core_sync;
  logic                        seen_q;
  logic                        seen_d;
  logic                        pulse_q;
  logic                        pulse_d;
  logic                        on_q;
  logic                        on_d;

  // Reset and strap enter the link domain through two flops each.
  level_sync #(.WIDTH(2)) u_link_sync (
    .clk   (ck),
    .d_in  ({srst, dev_x16}),
    .d_out (link_in_sync)
  );
  assign link_rst = link_in_sync[1];
  assign x16_sync = link_in_sync[0];

  // Command decode; READ and auto-precharge read share one code, A10 only picks precharge.
  assign cmd       = {cs_n, ras_n, cas_n, we_n};
  assign mode_load = (cmd == readout_pkg::CMD_LOAD) && (ba == readout_pkg::BANK_MODE3);
  assign any_read  = (cmd == readout_pkg::CMD_READ);
  assign pat_read  = any_read && mode_q[readout_pkg::BIT_ENABLE];
  assign norm_read = any_read && !mode_q[readout_pkg::BIT_ENABLE];

  // Select bits matter only once enabled; reserved codes and an unlocked DLL launch nothing.
  assign push = pat_read && dll_locked
                && (mode_q[readout_pkg::BIT_FSEL_HI:readout_pkg::BIT_FSEL_LO] == readout_pkg::FSEL_PATTERN);

  // Burst length per read: fixed by the base register or taken from A12 on the fly.
  always_comb
  begin
    unique case (burst_select)
      readout_pkg::BURST_FIXED8: req_chop = 1'b0;
      readout_pkg::BURST_OTF:    req_chop = !addr[readout_pkg::ADDR_CHOP];
      readout_pkg::BURST_FIXED4: req_chop = 1'b1;
      default:                   req_chop = 1'b0;
    endcase
  end

  // Register, strap and array-read toggle; nothing here writes the array.
  always_comb
  begin
    mode_d   = mode_q;
    wide_d   = wide_q;
    rd_tog_d = rd_tog_q ^ norm_read;
    if (link_rst)
    begin
      mode_d   = readout_pkg::MODE_RESET;
      wide_d   = x16_sync;
      rd_tog_d = 1'b0;
    end
    else if (mode_load)
    begin
      mode_d = {ba, addr};
    end
  end

  always_ff @(posedge ck)
  begin
    mode_q   <= mode_d;
    wide_q   <= wide_d;
    rd_tog_q <= rd_tog_d;
  end

  // Latency pipe: one slot per link cycle; only A2 and the chop choice are kept, other address bits drop.
  always_comb
  begin
    lat_v_d = {lat_v_q[readout_pkg::LAT_DEPTH-2:0], push};
    lat_c_d = {lat_c_q[readout_pkg::LAT_DEPTH-2:0], req_chop};
    lat_n_d = {lat_n_q[readout_pkg::LAT_DEPTH-2:0], req_chop && addr[readout_pkg::ADDR_NIBBLE]};
    if (link_rst)
    begin
      lat_v_d = '0;
      lat_c_d = '0;
      lat_n_d = '0;
    end
  end

  always_ff @(posedge ck)
  begin
    lat_v_q <= lat_v_d;
    lat_c_q <= lat_c_d;
    lat_n_q <= lat_n_d;
  end

  // The slot read at index RL-1 launches, so the first beat appears RL edges after the command.
  assign rl_sum      = {1'b0, additive_latency} + {1'b0, cas_read_latency};
  assign tap         = 5'(rl_sum - 6'h01);
  assign launch      = lat_v_q[tap];
  assign launch_chop = lat_c_q[tap];
  assign launch_nib  = lat_n_q[tap];
  assign reload      = launch && ((state_q == readout_pkg::ST_IDLE) || (beat_q == last_q));

  // Burst sequencer; a launch on the last beat continues seamlessly for back-to-back reads.
  always_comb
  begin
    state_d = state_q;
    beat_d  = beat_q;
    last_d  = last_q;
    dq_d    = 16'h0000;
    oe_d    = 1'b0;
    if (reload)
    begin
      state_d = readout_pkg::ST_SEND;
      beat_d  = launch_nib ? readout_pkg::START_UPPER : readout_pkg::START_LOWER;
      last_d  = beat_d + (launch_chop ? readout_pkg::LAST_CHOP : readout_pkg::LAST_FULL);
    end
    else
    begin
      unique case (state_q)
        readout_pkg::ST_IDLE: state_d = readout_pkg::ST_IDLE;
        readout_pkg::ST_SEND:
        begin
          if (beat_q == last_q)
            state_d = readout_pkg::ST_IDLE;
          else
            beat_d = beat_q + 3'h1;
        end
      endcase
    end
    if (state_d == readout_pkg::ST_SEND)
    begin
      oe_d     = 1'b1;
      dq_d[0]  = readout_pkg::CAL_PATTERN[beat_d];
      dq_d[8]  = wide_q && readout_pkg::CAL_PATTERN[beat_d];
    end
    if (link_rst)
    begin
      state_d = readout_pkg::ST_IDLE;
      beat_d  = 3'h0;
      last_d  = 3'h0;
      dq_d    = 16'h0000;
      oe_d    = 1'b0;
    end
  end

  always_ff @(posedge ck)
  begin
    state_q <= state_d;
    beat_q  <= beat_d;
    last_q  <= last_d;
    dq_q    <= dq_d;
    oe_q    <= oe_d;
  end

  assign dq_o  = dq_q;
  assign dq_oe = oe_q;

  // Core side: enable level and read toggle cross as levels; the toggle edge becomes a pulse.
  level_sync #(.WIDTH(2)) u_core_sync (
    .clk   (clk),
    .d_in  ({mode_q[readout_pkg::BIT_ENABLE], rd_tog_q}),
    .d_out (core_sync)
  );

  always_comb
  begin
    on_d    = core_sync[1];
    seen_d  = core_sync[0];
    pulse_d = core_sync[0] ^ seen_q;
    if (srst)
    begin
      on_d    = 1'b0;
      seen_d  = core_sync[0]; // Tracks the toggle so no false pulse follows reset.
      pulse_d = 1'b0;
    end
  end

  // A read toggle that lands during srst is dropped; the core is being reset anyway.
  always_ff @(posedge clk)
  begin
    on_q    <= on_d;
    seen_q  <= seen_d;
    pulse_q <= pulse_d;
  end

  assign readout_on       = on_q;
  assign array_read_pulse = pulse_q;

  // Checks on the link domain.
  default clocking cb_link @(posedge ck); endclocking
  default disable iff (link_rst);

  sequence s_chop_start;
    reload && launch_chop;
  endsequence

  sequence s_quiet_four;
    (!launch)[*4];
  endsequence

  a_mode_hold: assert property (!mode_load |=> $stable(mode_q))
    else $error("mode register changed without a load");
  a_mode_load: assert property (mode_load |=> mode_q == $past({ba, addr}))
    else $error("mode register load did not capture bank and address");
  a_other_lines: assert property (oe_q |-> (dq_q[7:1] == 7'h00) && (dq_q[15:9] == 7'h00))
    else $error("non-prime data line driven high");
  a_upper_prime: assert property (oe_q |-> dq_q[8] == (wide_q && dq_q[0]))
    else $error("upper prime line does not follow lower prime line");
  a_burst_start: assert property (reload |=> oe_q && !dq_q[0])
    else $error("burst did not start with a zero beat");
  a_full_length: assert property (reload && !launch_chop |=> oe_q[*8])
    else $error("full burst shorter than eight beats");
  a_chop_length: assert property (s_chop_start ##1 s_quiet_four |=> !oe_q)
    else $error("chopped burst not four beats long");
  a_alternate: assert property (oe_q && $past(oe_q) |-> dq_q[0] != $past(dq_q[0]))
    else $error("pattern beats do not alternate");
  a_array_route: assert property (any_read && !mode_q[readout_pkg::BIT_ENABLE] |=> rd_tog_q != $past(rd_tog_q))
    else $error("normal read not forwarded to the array");
  a_reset_clear: assert property (disable iff (1'b0) link_rst |=> (mode_q == readout_pkg::MODE_RESET) && !oe_q)
    else $error("reset did not clear readout state");

endmodule : calibration_readout

// *** bench/ctrl_model.sv ***
/*
  Controller model: drives the command and address pins of the readout block on the link clock.
  Assumes one bench process calls its tasks, each entered just after a link edge.
*/
`timescale 1ns/1ns
module ctrl_model #(
  parameter int QUIET     = 4,
  parameter int MODE_WAIT = 12
) (
  // Link clock.
  input  wire logic        ck,
  // Command and address pins.
  output logic             cs_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             we_n,
  output logic [2:0]       ba,
  output logic [13:0]      addr
);
  // Link edge count, read by the bench to place expected beats.
  int cyc = 0;

  always @(posedge ck)
    cyc <= cyc + 1;

  // Pins rest deselected until the first command.
  initial
  begin
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    ba   = 3'h0;
    addr = 14'h0000;
  end

  // Waits n link edges and leaves the caller just after the last one.
  task automatic idle(input int n);
    repeat (n) @(posedge ck);
    #1;
  endtask : idle

  // One command for one cycle; released lines flip so a stale value never looks valid.
  task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a, input int gap);
    {cs_n, ras_n, cas_n, we_n} = c;
    ba   = b;
    addr = a;
    idle(1);
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    ba   = ~b;
    addr = ~a;
    if (gap > 1)
      idle(gap - 1);
  endtask : cmd

  // Mode load framed by quiet time before and the set and update delays after.
  task automatic load(input logic [2:0] b, input logic [13:0] a);
    idle(QUIET);
    cmd(readout_pkg::CMD_LOAD, b & ~readout_pkg::MODE_RSVD_MASK[16:14],
        a & ~readout_pkg::MODE_RSVD_MASK[13:0], 2);
    idle(MODE_WAIT);
  endtask : load

  // Reads and calibration-mode loads are the only commands used in readout mode; column bits 1:0 stay zero.
  task automatic read(input logic a12, input logic a2, input logic [13:0] dc, input int gap);
    cmd(readout_pkg::CMD_READ, dc[2:0], {dc[13], a12, dc[11:3], a2, 2'h0}, gap);
  endtask : read
endmodule : ctrl_model

// *** bench/testbench.sv ***
/*
  Self-checking bench for the calibration readout block with a controller model on the link.
  Assumes 25 MHz core clock and a 32 ns link clock of unrelated phase.
*/
`timescale 1ns/1ns
module testbench;
  logic        clk              = 1'b0;
  logic        ck               = 1'b0;
  logic        srst;
  logic        dll_locked;
  logic        dev_x16;
  logic [1:0]  burst_select;
  logic [4:0]  additive_latency;
  logic [4:0]  cas_read_latency;
  logic        cs_n;
  logic        ras_n;
  logic        cas_n;
  logic        we_n;
  logic [2:0]  ba;
  logic [13:0] addr;
  logic [15:0] dq_o;
  logic        dq_oe;
  logic        readout_on;
  logic        array_read_pulse;
  int          error_cnt        = 0;
  int          n_compared       = 0;
  int          pulses           = 0;
  int          check_on         = 0;
  int          r;
  int          p;
  logic [15:0] exp_dq[int];

  // Two unrelated clocks; the link clock starts off phase on purpose.
  initial forever #20 clk = ~clk;
  initial
  begin
    #7;
    forever #16 ck = ~ck;
  end

  calibration_readout calibration_readout_inst (
    .clk(clk), .srst(srst), .ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .addr(addr), .burst_select(burst_select), .additive_latency(additive_latency),
    .cas_read_latency(cas_read_latency), .dll_locked(dll_locked), .dev_x16(dev_x16),
    .dq_o(dq_o), .dq_oe(dq_oe), .readout_on(readout_on), .array_read_pulse(array_read_pulse)
  );

  ctrl_model ctrl_model_inst (
    .ck(ck), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr)
  );

  task automatic check(input string what, input logic [15:0] e, input logic [15:0] got);
    n_compared++;
    if (got !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, got);
    end
  endtask : check

  // Every link edge: the data lines carry the predicted beat or stay undriven.
  always @(posedge ck)
  begin
    #2;
    if (check_on != 0)
    begin
      if (exp_dq.exists(ctrl_model_inst.cyc))
      begin
        check("dq_oe", 16'h0001, {15'h0, dq_oe});
        check("dq_o", exp_dq[ctrl_model_inst.cyc], dq_o);
      end
      else
        check("idle dq_oe", 16'h0000, {15'h0, dq_oe});
    end
  end

  // Normal reads are counted on the core side, sampled once the pulse has settled.
  always @(posedge clk)
  begin
    #2;
    if (array_read_pulse === 1'b1)
      pulses++;
  end

  // Predicts one pattern read from the rules, then issues it spaced by its own burst length.
  task automatic pread(input logic a12, input logic a2, input logic want);
    int at;
    int rl;
    int len;
    int st;
    rl  = additive_latency + cas_read_latency;
    len = (burst_select == 2'h2 || (burst_select == 2'h1 && !a12)) ? 4 : 8;
    st  = (len == 4 && a2) ? 4 : 0;
    at  = ctrl_model_inst.cyc + 1;
    for (int k = 0; k < len; k++)
      if (want)
        exp_dq[at + rl + k] = ((st + k) % 2 == 1) ? (dev_x16 ? 16'h0101 : 16'h0001) : 16'h0000;
    ctrl_model_inst.read(a12, (len == 4) & a2, 14'($urandom), len);
  endtask : pread

  task automatic ron(input logic e);
    repeat (8) @(posedge clk);
    #1;
    check("readout_on", {15'h0, e}, {15'h0, readout_on});
    ctrl_model_inst.idle(1);
  endtask : ron

  task automatic nread();
    p = pulses;
    ctrl_model_inst.read(1'b1, 1'b0, 14'($urandom), 4);
    repeat (10) @(posedge clk);
    check("array_read_pulse count", 16'(p + 1), 16'(pulses));
    ctrl_model_inst.idle(1);
  endtask : nread

  task automatic finish_test();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // A hang ends the run after far longer than the tests need.
  initial
  begin
    #1000000;
    error_cnt++;
    finish_test();
  end

  // Main sequence: first pass on a narrow part, second on a wide one after a reset in readout mode.
  initial
  begin
    r = $urandom(32'h0395);
    // Settings start here rather than in the declarations so every input is a driven stimulus.
    srst             = 1'b1;
    dll_locked       = 1'b1;
    dev_x16          = 1'b0;
    burst_select     = 2'h0;
    additive_latency = 5'h00;
    cas_read_latency = 5'h05;
    repeat (4) @(posedge clk);
    #1;
    srst = 1'b0;
    ctrl_model_inst.idle(6);
    check_on = 1;
    for (int pass = 0; pass < 2; pass++)
    begin
      ctrl_model_inst.load(3'h3, 14'h0003);
      ron(1'b0);
      nread();
      $display("test normal_read done");
      ctrl_model_inst.load(3'h0, 14'h0004);
      ron(1'b0);
      ctrl_model_inst.load(3'h3, 14'h0004);
      ron(1'b1);
      p = pulses;
      for (int m = 0; m < 8; m++)
      begin
        additive_latency = 5'($urandom_range(0, 8));
        cas_read_latency = 5'($urandom_range(1, 12));
        burst_select     = 2'(m >> 1);
        r = $urandom;
        pread(m[0], r[0], 1'b1);
        pread(m[0], r[1], 1'b1);
        ctrl_model_inst.idle(60);
      end
      check("pulses in readout", 16'(p), 16'(pulses));
      $display("test pattern_read done");
      for (int f = 1; f < 5; f++)
      begin
        dll_locked = (f != 4);
        ctrl_model_inst.load(3'h3, 14'h0004 | 14'(f & 3));
        pread(1'b1, 1'b0, 1'b0);
        ctrl_model_inst.idle(40);
      end
      dll_locked = 1'b1;
      $display("test reserved_select done");
      ctrl_model_inst.load(3'h3, 14'h0004);
      @(posedge clk);
      #1;
      dev_x16 = 1'b1;
      srst    = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      srst = 1'b0;
      ctrl_model_inst.idle(6);
      ron(1'b0);
      nread();
      $display("test reset_in_readout done");
    end
    finish_test();
  end
endmodule : testbench
